// ### hdl/hbp_host.sv
// Purpose: host side driver of the peripheral's parallel bus pins
// Assumes: software port with read data one cycle after the read strobe
// Notes:   one transfer at a time; busy shows in the status register
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module hbp_host
	import hbp_pkg::*;
#(
	parameter int AW = 20,
	parameter int DW = 16
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	input  wire logic [2:0]    sw_addr,
	input  wire logic [31:0]   sw_wdata,
	input  wire logic          sw_wr,
	input  wire logic          sw_rd,
	output logic      [31:0]   sw_rdata,
	output logic      [AW-1:0] addr_o,
	output logic      [DW-1:0] data_o,
	output logic               data_oe_b,
	input  wire logic [DW-1:0] data_i,
	output logic               ale_o,
	output logic               rd_e_ds_o,
	output logic               wr_rw_o,
	output logic               ube_program_fetch_strobe_o,
	output logic               dev_rst_o
);
	import hbp_pkg::*;

	typedef struct packed {
		hbp_st_t          st;
		logic [CFG_W-1:0] cfg;
		logic [AW-1:0]    addr;
		logic [DW-1:0]    wdat;
		logic             wr;
		logic             fetch;
		logic             upper;
		logic [3:0]       cnt;
		logic [DW-1:0]    rdat;
		logic [DW-1:0]    sync1;
		logic [DW-1:0]    sync2;
		logic [31:0]      sw_rdata;
	} hbp_state_t;

	hbp_state_t s_ff;
	hbp_state_t nxt_s;

	logic bus16;
	logic muxed;
	logic style;
	logic dssel;
	logic in_stb;
	logic in_addr;

	assign bus16 = s_ff.cfg[CFG_BUS16];
	assign muxed = s_ff.cfg[CFG_MUXED];
	assign style = s_ff.cfg[CFG_STYLE];
	assign dssel = s_ff.cfg[CFG_DSSEL];
	assign in_stb = (s_ff.st == ST_STB);
	assign in_addr = (s_ff.st == ST_ALE) || (s_ff.st == ST_HOLD);

	// 4-bit cycle count from an int constant
	function automatic logic [3:0] cyc(input int n);
		return 4'(n - 1);
	endfunction

	// =========================================================
	// sequencing and software registers
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sync1 = data_i;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.sw_rdata = 32'h0000_0000;
		if (sw_rd) begin
			case (sw_addr)
			REG_CFG:  nxt_s.sw_rdata = 32'(s_ff.cfg);
			REG_ADDR: nxt_s.sw_rdata = 32'(s_ff.addr);
			REG_WDAT: nxt_s.sw_rdata = 32'(s_ff.wdat);
			REG_STAT: nxt_s.sw_rdata = {31'h0, s_ff.st != ST_IDLE};
			REG_RDAT: nxt_s.sw_rdata = 32'(s_ff.rdat);
			default:  nxt_s.sw_rdata = 32'h0000_0000;
			endcase
		end
		// configuration and operands only change while idle
		if (sw_wr && s_ff.st == ST_IDLE) begin
			case (sw_addr)
			REG_CFG:  nxt_s.cfg = sw_wdata[CFG_W-1:0];
			REG_ADDR: nxt_s.addr = sw_wdata[AW-1:0];
			REG_WDAT: nxt_s.wdat = sw_wdata[DW-1:0];
			REG_CMD: begin
				nxt_s.wr = sw_wdata[CMD_WRITE];
				nxt_s.fetch = sw_wdata[CMD_FETCH] & ~sw_wdata[CMD_WRITE];
				nxt_s.upper = sw_wdata[CMD_UPPER];
				if (sw_wdata[CMD_RESET]) begin
					nxt_s.st = ST_RST;
					nxt_s.cnt = cyc(RST_CYC);
				end else if (sw_wdata[CMD_GO]) begin
					nxt_s.st = ST_ALE;
					nxt_s.cnt = cyc(ALE_CYC);
				end
			end
			default: ;
			endcase
		end
		case (s_ff.st)
		ST_IDLE: ;
		ST_RST, ST_ALE: begin
			if (s_ff.cnt != 4'h0) begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
			end else begin
				nxt_s.st = (s_ff.st == ST_RST) ? ST_IDLE : ST_HOLD;
			end
		end
		ST_HOLD: begin
			// latch closed as ST_ALE ended; address held one cycle before the strobe opens the data phase
			nxt_s.st = ST_STB;
			nxt_s.cnt = cyc(STB_CYC);
		end
		ST_STB: begin
			// extra cycles cover the input synchroniser delay
			if (s_ff.cnt != 4'h0) begin
				nxt_s.cnt = s_ff.cnt - 4'h1;
			end else begin
				if (!s_ff.wr) begin
					nxt_s.rdat = s_ff.sync2;
				end
				nxt_s.st = ST_REC;
			end
		end
		ST_REC:  nxt_s.st = ST_IDLE;
		default: nxt_s.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_ff <= '0;
			s_ff.st <= ST_IDLE;
			s_ff.cfg <= CFG_RST_VAL;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// =========================================================
	// pins
	assign sw_rdata = s_ff.sw_rdata;
	assign addr_o = s_ff.addr;
	// reset pin polarity follows the device's setting
	assign dev_rst_o = (s_ff.st == ST_RST) ~^ s_ff.cfg[CFG_RST_HI];
	// open during ST_ALE only, closed from ST_HOLD on
	assign ale_o = (s_ff.st == ST_ALE) ~^ s_ff.cfg[CFG_ALE_HI];

	always_comb begin
		data_o = s_ff.wdat;
		data_oe_b = 1'b1;
		if (muxed && in_addr) begin
			data_o = s_ff.addr[DW-1:0];
			data_oe_b = 1'b0;
		end else if (s_ff.wr && in_stb) begin
			data_oe_b = 1'b0;
		end
		// bus left free on reads so the device may drive it
		if (!s_ff.wr && in_stb) begin
			data_oe_b = 1'b1;
		end
	end

	always_comb begin
		rd_e_ds_o = 1'b1;
		wr_rw_o = 1'b1;
		case ({style, dssel})
		2'b10: begin
			rd_e_ds_o = in_stb && !s_ff.fetch;
			wr_rw_o = !s_ff.wr;
		end
		2'b11: begin
			rd_e_ds_o = !(in_stb && !s_ff.fetch);
			wr_rw_o = !s_ff.wr;
		end
		default: begin
			rd_e_ds_o = !(in_stb && !s_ff.wr && !s_ff.fetch);
			wr_rw_o = !(in_stb && s_ff.wr);
		end
		endcase
	end

	always_comb begin
		if (bus16) begin
			// upper half and port B need the enable low
			ube_program_fetch_strobe_o = !s_ff.upper;
		end else if (s_ff.cfg[CFG_SPLIT]) begin
			ube_program_fetch_strobe_o = !(in_stb && s_ff.fetch);
		end else begin
			ube_program_fetch_strobe_o = 1'b1;
		end
	end

	// =========================================================
	// checks
	property p_rst_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_ff.st == ST_RST) |-> (s_ff.st == ST_RST) [*3];
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("device reset shorter than 100 ns");

	property p_upper_low;
		@(posedge ref_clk) disable iff (!rst_b)
		(in_stb && bus16 && s_ff.upper) |-> !ube_program_fetch_strobe_o;
	endproperty
	a_upper_low: assert property (p_upper_low)
		else $error("upper byte access without enable low");

	property p_e_dir;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(in_stb) && style && !dssel && !s_ff.fetch |->
			(rd_e_ds_o && wr_rw_o == !s_ff.wr) [*5];
	endproperty
	a_e_dir: assert property (p_e_dir)
		else $error("enable pulse or direction wrong");

	property p_ds_low;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(in_stb) && style && dssel && !s_ff.fetch |->
			(!rd_e_ds_o && wr_rw_o == !s_ff.wr) [*5] ##1 rd_e_ds_o;
	endproperty
	a_ds_low: assert property (p_ds_low)
		else $error("data strobe not low for the access");

	property p_program_fetch_strobe_tied;
		@(posedge ref_clk) disable iff (!rst_b)
		(!bus16 && !s_ff.cfg[CFG_SPLIT]) |-> ube_program_fetch_strobe_o;
	endproperty
	a_program_fetch_strobe_tied: assert property (p_program_fetch_strobe_tied)
		else $error("fetch strobe not high in combined spaces");

	property p_sep_wr;
		@(posedge ref_clk) disable iff (!rst_b)
		(!style && in_stb && s_ff.wr) |-> (!wr_rw_o && rd_e_ds_o);
	endproperty
	a_sep_wr: assert property (p_sep_wr)
		else $error("write strobe not low alone");

	property p_read_free;
		@(posedge ref_clk) disable iff (!rst_b)
		(in_stb && !s_ff.wr) |-> data_oe_b;
	endproperty
	a_read_free: assert property (p_read_free)
		else $error("host drives data during a read");

	property p_ale_close;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_ff.st == ST_ALE) |=> (ale_o != $past(ale_o)) ##1 in_stb;
	endproperty
	a_ale_close: assert property (p_ale_close)
		else $error("address latch not closed before data phase");

	property p_fetch_only;
		@(posedge ref_clk) disable iff (!rst_b)
		(in_stb && s_ff.fetch && !bus16 && s_ff.cfg[CFG_SPLIT]) |->
			(!ube_program_fetch_strobe_o && wr_rw_o);
	endproperty
	a_fetch_only: assert property (p_fetch_only)
		else $error("fetch strobe not alone during a fetch");
endmodule

// ### hdl/hbp_pkg.sv
// Purpose: constants for the host bus port controller
// Assumes: ref_clk at 25 MHz
// Notes:   device map offsets count from the I/O block select base
//
// Operation
// - 16-bit: word registers at +2,+4,+6; port B needs upper enable low
// - direction high read, low write; transfer on high enable pulse
// - data-strobe style: strobe active low, direction picks read/write
// - combined spaces: fetch strobe held high; reads by read style
// - reset asynchronous, programmable polarity, held at least 100 ns
package hbp_pkg;
	localparam int CLK_NS = 40;
	localparam int T_RST_NS = 100;
	localparam int T_ACC_NS = 120;
	localparam int T_ALE_NS = 40;
	localparam int SYNC_STAGES = 2;
	localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int ALE_CYC = (T_ALE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STB_CYC = ACC_CYC + SYNC_STAGES;
	// device map, offsets from the I/O block select base
	localparam logic [7:0] DEV_PIN_A = 8'h02;
	localparam logic [7:0] DEV_PIN_B = 8'h03;
	localparam logic [7:0] DEV_DIR_A = 8'h04;
	localparam logic [7:0] DEV_DIR_B = 8'h05;
	localparam logic [7:0] DEV_DAT_A = 8'h06;
	localparam logic [7:0] DEV_DAT_B = 8'h07;
	localparam logic [7:0] DEV_PAGE = 8'h18;
	// controller registers
	localparam logic [2:0] REG_CFG = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDAT = 3'h2;
	localparam logic [2:0] REG_CMD = 3'h3;
	localparam logic [2:0] REG_STAT = 3'h4;
	localparam logic [2:0] REG_RDAT = 3'h5;
	// cfg bits
	localparam int CFG_BUS16 = 0;
	localparam int CFG_MUXED = 1;
	localparam int CFG_STYLE = 2;
	localparam int CFG_DSSEL = 3;
	localparam int CFG_ALE_HI = 4;
	localparam int CFG_RST_HI = 5;
	localparam int CFG_SPLIT = 6;
	localparam int CFG_W = 7;
	// cmd bits
	localparam int CMD_GO = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_FETCH = 2;
	localparam int CMD_UPPER = 3;
	localparam int CMD_RESET = 4;
	localparam logic [CFG_W-1:0] CFG_RST_VAL = 7'h00;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RST, ST_ALE, ST_HOLD, ST_STB, ST_REC
	} hbp_st_t;
endpackage

// ### tb/hbp_dev.sv
// Purpose: behavioural device at the far end of the host port
// Assumes: io block select decodes address bits 19..8 as IO_HI
// Notes:   released data lanes toggle so stale values never pass
`timescale 1ns/10ps
module hbp_dev #(
	parameter logic [11:0] IO_HI = 12'h010,
	parameter logic [7:0]  PIN_A = 8'hA5,
	parameter logic [7:0]  PIN_B = 8'h3C
) (
	input  wire logic        ref_clk,
	input  wire logic [6:0]  cfg,
	input  wire logic [19:0] a,
	input  wire logic [15:0] dq_h,
	output logic      [15:0] dq_d,
	input  wire logic        ale,
	input  wire logic        rde,
	input  wire logic        rw,
	input  wire logic        ubp,
	input  wire logic        rst
);
	logic [19:0] lat;
	logic [15:0] dir, dat, src, rv, wd, mk, last = 16'h0000;
	logic [3:0]  pg;
	logic [1:0]  wm, dm;
	logic        rd, wr, lo, hi, sel, r_on, stb;
	logic [7:0]  ram [2048];
	logic [7:0]  eprom_bank_selects, rb;
	logic        fet, e_rd, m_rd, sram_select;
	// ==========
	// strobe, lane and select decode
	assign r_on = cfg[5] ? rst : !rst;
	always_latch
		if (ale == cfg[4])
			lat <= cfg[1] ? {a[19:16], dq_h} : a;
	assign stb = rde ^ cfg[3];
	assign rd = cfg[2] ? rw & stb : !rde;
	assign wr = cfg[2] ? !rw & stb : !rw;
	assign lo = !cfg[0] | !lat[0];
	assign hi = cfg[0] & !ubp;
	assign sel = lat[19:8] == IO_HI && !r_on;
	assign wm = cfg[0] ? {hi, lo} : {lat[0], !lat[0]};
	assign dm = cfg[0] ? {hi, lo} : 2'b01;
	assign wd = cfg[0] ? dq_h : {2{dq_h[7:0]}};
	assign mk = {{8{wm[1]}}, {8{wm[0]}}};
	assign rv = cfg[0] ? src : {8'h00, lat[0] ? src[15:8] : src[7:0]};
	always_comb
		case (lat[7:1])
			7'h01: src = {PIN_B, PIN_A};
			7'h02: src = dir;
			7'h03: src = dat;
			7'h0C: src = {12'h000, pg};
			default: src = 16'h0000;
		endcase
	// ==========
	// memory decode: banks at 0x2n000, sram at 0x08000
	// memories answer on the low byte lane only
	assign fet = !cfg[0] & cfg[6] & !ubp;
	always_comb
		for (int n = 0; n < 8; n++)
			eprom_bank_selects[n] = lat[19:15] == 5'h04
				&& lat[14:12] == 3'(n) && !r_on;
	assign sram_select = lat[19:11] == 9'h010 && !r_on;
	assign e_rd = |eprom_bank_selects && (cfg[6] ? fet : rd);
	assign m_rd = sram_select && rd;
	// bank byte: marker bit, bank number, low address nibble
	assign rb = |eprom_bank_selects ? {1'b1, lat[14:12], lat[3:0]}
		: ram[lat[10:0]];
	// ==========
	// data lanes and registers
	always_comb
		for (int i = 0; i < 2; i++)
			dq_d[i*8 +: 8] = sel && rd && dm[i] ? rv[i*8 +: 8]
				: (e_rd || m_rd) && i == 0 ? rb
				: ~last[i*8 +: 8];
	always @(posedge ref_clk)
		last <= dq_d;
	always @(posedge ref_clk or posedge r_on)
		if (r_on) begin
			dir <= 16'h0000;
			dat <= 16'h0000;
			pg <= 4'h0;
		end else if (sel && wr)
			case (lat[7:1])
				7'h02: dir <= dir & ~mk | wd & mk;
				7'h03: dat <= dat & ~mk | wd & mk;
				7'h0C: pg <= wd[3:0];
				default: ; // pin levels ignore writes
			endcase
	always @(posedge ref_clk)
		if (sram_select && wr)
			ram[lat[10:0]] <= dq_h[7:0];
endmodule

// ### tb/host_bus_port_decode_tb.sv
// Purpose: self-checking bench of the host bus port controller
// Assumes: device model answers at io block 0x010xx
// Notes:   8-bit transfers compare the low data byte only
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module host_bus_port_decode_tb;
	import hbp_pkg::*;
	logic        ref_clk = 1'b0, rst_b = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
	logic [2:0]  sw_addr = 3'h0;
	logic [31:0] sw_wdata = 32'h0, sw_rdata, v;
	logic [19:0] addr_o;
	logic [15:0] data_o, data_i, dq_d;
	logic [6:0]  cfg = 7'h00;
	logic        data_oe_b, ale_o, rd_e_ds_o, wr_rw_o, ube_program_fetch_strobe_o, dev_rst_o;
	int          err_count = 0, tests_run = 0, cyc = 0;
	// ==========
	// wiring, clock and watchdog
	assign data_i = data_oe_b ? dq_d : data_o;
	hbp_host hbp_host_inst (.ref_clk, .rst_b, .sw_addr, .sw_wdata, .sw_wr,
		.sw_rd, .sw_rdata, .addr_o, .data_o, .data_oe_b, .data_i, .ale_o,
		.rd_e_ds_o, .wr_rw_o, .ube_program_fetch_strobe_o, .dev_rst_o);
	hbp_dev hbp_dev_inst (.ref_clk, .cfg, .a(addr_o), .dq_h(data_o), .dq_d,
		.ale(ale_o), .rde(rd_e_ds_o), .rw(wr_rw_o), .ubp(ube_program_fetch_strobe_o),
		.rst(dev_rst_o));
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			complete_run;
		end
	end
	// ==========
	// software port cycles
	task automatic wr(input logic [2:0] i, input logic [31:0] d);
		@(posedge ref_clk);
		sw_addr <= i;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] i);
		@(posedge ref_clk);
		sw_addr <= i;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask
	task automatic setc(input logic [6:0] c);
		wr(REG_CFG, {25'h0, c});
		cfg <= c;
	endtask
	// one device transfer at any address; read data lands in v
	task automatic xfer(input logic [19:0] a, input logic [15:0] d,
		input logic [4:0] c);
		wr(REG_ADDR, {12'h000, a});
		wr(REG_WDAT, {16'h0, d});
		wr(REG_CMD, {27'h0, c});
		for (int k = 0; k < 30; k++) begin
			rd(REG_STAT);
			if (v[0] === 1'b0)
				break;
		end
		`CHK("idle", 1'b0, v[0])
		rd(REG_RDAT);
	endtask
	// transfer within the io block
	task automatic go(input logic [7:0] o, input logic [15:0] d,
		input logic [4:0] c);
		xfer({12'h010, o}, d, c);
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		#1 `CHK("ale", 1'b1, ale_o)
		`CHK("devrst", 1'b1, dev_rst_o)
		`CHK("oe", 1'b1, data_oe_b)
		rd(REG_CFG);
		`CHK("cfg", 32'h0, v)
		rd(3'h7);
		`CHK("unmapped", 32'h0, v)
	endtask
	task automatic t_devrst;
		// device must see a reset before its first use
		go(8'h00, 16'h0000, 5'h10);
		go(DEV_DIR_A, 16'h00FF, 5'h03);
		go(8'h00, 16'h0000, 5'h11);
		go(DEV_DIR_A, 16'h0000, 5'h01);
		`CHK("dir after reset", 8'h00, v[7:0])
	endtask
	task automatic t_ports;
		logic [7:0] e;
		for (int i = 4; i < 8; i++)
			go(8'(i), {8'h00, 4'(i), 4'(~i)}, 5'h03);
		go(DEV_PIN_A, 16'h0000, 5'h03);
		for (int i = 2; i < 8; i++) begin
			go(8'(i), 16'h0000, 5'h01);
			e = i == 2 ? 8'hA5 : i == 3 ? 8'h3C : {4'(i), 4'(~i)};
			`CHK("port reg", e, v[7:0])
		end
	endtask
	task automatic t_styles;
		logic [6:0] cs [3] = '{7'h12, 7'h04, 7'h1E};
		for (int k = 0; k < 3; k++) begin
			setc(cs[k]);
			go(DEV_PAGE, 16'h00F0 | 16'(k + 5), 5'h03);
			go(DEV_PAGE, 16'h0000, 5'h01);
			`CHK("page", 8'(k + 5), v[7:0])
		end
	endtask
	task automatic t_word;
		setc(7'h01);
		go(DEV_DIR_A, 16'hBEEF, 5'h0B);
		go(DEV_DIR_A, 16'h1234, 5'h03);
		go(DEV_DIR_A, 16'h0000, 5'h09);
		`CHK("word", 16'hBE34, v[15:0])
	endtask
	task automatic t_mem;
		setc(7'h40);
		xfer(20'h25003, 16'h0000, 5'h05);
		`CHK("fetch bank", 8'hD3, v[7:0])
		xfer(20'h08123, 16'h005A, 5'h03);
		xfer(20'h08123, 16'h0000, 5'h01);
		`CHK("sram", 8'h5A, v[7:0])
		setc(7'h00);
		xfer(20'h22007, 16'h0000, 5'h01);
		`CHK("combined bank", 8'hA7, v[7:0])
	endtask
	task automatic t_rsthi;
		setc(7'h20);
		go(DEV_PAGE, 16'h0009, 5'h03);
		go(DEV_PAGE, 16'h0000, 5'h01);
		`CHK("page hi", 8'h09, v[7:0])
		`CHK("rst idle", 1'b0, dev_rst_o)
		go(8'h00, 16'h0000, 5'h10);
		go(DEV_PAGE, 16'h0000, 5'h01);
		`CHK("page cleared", 8'h00, v[7:0])
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset;
		t_devrst;
		t_ports;
		t_styles;
		t_word;
		t_mem;
		t_rsthi;
		complete_run;
	end
endmodule
